// [dv/pmc_clock_ctrl_props.sv]
// Purpose: Port-level properties of the clock configuration block
// Assumes: Clock pins far slower than hclk
// Notes:   Bound to the design at the foot
`timescale 1ns/10ps
module pmc_clock_ctrl_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pll_a_enable,
  input wire logic        pll_b_enable,
  input wire logic [11:0] pll_a_mult,
  input wire logic [11:0] pll_b_mult,
  input wire logic        pll_a_ref_tick,
  input wire logic        pll_b_ref_tick,
  input wire logic        mck_tick,
  input wire logic [3:0]  pck_tick,
  input wire logic        usb_tick
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Request taken on the bus
  wire rq = hsel && htrans[1] && hready;
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("Response not okay");
  a_read_wait: assert property (rq && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait wrong");
  a_write_nowait: assert property (rq && hwrite |=> hreadyout)
    else $error("Write stalled");
  a_mult_a: assert property (hresetn |=> pll_a_enable == (pll_a_mult != 12'h001) && |pll_a_mult)
    else $error("PLL A multiplier wrong");
  a_mult_b: assert property (hresetn |=> pll_b_enable == (pll_b_mult != 12'h001) && |pll_b_mult)
    else $error("PLL B multiplier wrong");
  a_mck_pulse: assert property (mck_tick |=> !mck_tick)
    else $error("Master tick too long");
  a_usb_pulse: assert property ($rose(usb_tick) |=> $fell(usb_tick))
    else $error("USB tick too long");
  a_pck_pulse: assert property (|pck_tick |=> (pck_tick & $past(pck_tick)) == 4'h0)
    else $error("Programmable tick too long");
  a_ref_a: assert property (pll_a_ref_tick |=> !pll_a_ref_tick [*2])
    else $error("PLL A reference tick too long");
  a_ref_b: assert property (pll_b_ref_tick |=> !pll_b_ref_tick)
    else $error("PLL B reference tick too long");
  // Main scenarios reached
  c_read: cover property (rq && !hwrite);
  c_pll_on: cover property ($rose(pll_a_enable));
  c_usb: cover property (usb_tick);
endmodule
bind pmc_clock_ctrl pmc_clock_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .pll_a_enable(pll_a_enable), .pll_b_enable(pll_b_enable),
  .pll_a_mult(pll_a_mult), .pll_b_mult(pll_b_mult), .pll_a_ref_tick(pll_a_ref_tick),
  .pll_b_ref_tick(pll_b_ref_tick), .mck_tick(mck_tick), .pck_tick(pck_tick),
  .usb_tick(usb_tick));

// [dv/pmc_clock_ctrl_test.sv]
// Purpose: Self-checking bench of the clock configuration block
// Assumes: Pins toggle at fixed hclk counts: slow 24, main 3, A 4, B 6
// Notes:   Tick spacing is measured in hclk cycles
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t %h %h", $time, a, b); end end
module pmc_clock_ctrl_test;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, v;
  logic [1:0]  htrans = 0, pfr_a, pfr_b;
  logic [3:0]  pin = 0, pck_tick;
  logic [11:0] mul_a, mul_b;
  logic        hreadyout, ref_a, ref_b, en_a, en_b, mck_tick, usb_tick, irq, oe, ob;
  int          bad_count = 0, tests_run = 0, pc[4], n, m, r, s, pr;
  int          hp[4] = '{24, 3, 4, 6};
  int          sp[4] = '{48, 6, 8, 12};
  // Ticks: 0 A ref, 1 B ref, 2 master, 3..6 programmable, 7 USB
  wire [7:0]   tk = {usb_tick, pck_tick, mck_tick, ref_b, ref_a};
  always #2.5 hclk = ~hclk;
  // Free-running clock pins
  always @(posedge hclk)
    for (int i = 0; i < 4; i++)
      if (pc[i] == hp[i] - 1)
      begin
        pc[i] <= 0;
        pin[i] <= ~pin[i];
      end
      else
        pc[i] <= pc[i] + 1;
  pmc_clock_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .slow_clk_pin(pin[0]),
    .main_clk_pin(pin[1]), .pll_a_clk_pin(pin[2]), .pll_b_clk_pin(pin[3]),
    .osc_enable(oe), .osc_bypass(ob), .pll_a_ref_tick(ref_a), .pll_b_ref_tick(ref_b),
    .pll_a_enable(en_a), .pll_b_enable(en_b), .pll_a_mult(mul_a), .pll_b_mult(mul_b),
    .pll_a_freq_range(pfr_a), .pll_b_freq_range(pfr_b), .mck_tick(mck_tick),
    .pck_tick(pck_tick), .usb_tick(usb_tick), .irq(irq));
  // One single AHB-Lite transfer
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Spacing of the second interval between ticks, 0 when none come
  task per(input int i);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(posedge hclk);
        n++;
      end
      while (tk[i] !== 1'b1 && n < 1000);
      n = (n < 1000) ? n : 0;
    end
  endtask
  task results;
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #400us;
    bad_count++;
    results;
  end
  initial
  begin
    void'($urandom(32'h59c3005b));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xf(0, 8'h08, 0);
    `CHK(q, 32'h2000_0000)
    xf(0, 8'h04, 0);
    `CHK(q[16], 1'b0)
    xf(1, 8'h00, 32'h101);
    repeat (326) @(posedge hclk);
    `CHK({ob, oe}, 2'b01)
    xf(0, 8'h38, 0);
    `CHK(q[0], 1'b0)
    repeat (100) @(posedge hclk);
    xf(0, 8'h38, 0);
    `CHK(q[0], 1'b1)
    repeat (1920) @(posedge hclk);
    xf(0, 8'h04, 0);
    `CHK(q[16:0], {1'b1, 16'd128})
    for (int p = 0; p < 2; p++)
    begin
      m = $urandom_range(1, 2047);
      r = $urandom_range(0, 3);
      v = {4'h2, 1'b0, 11'(m), 2'(r), 6'd2, 8'd1};
      xf(1, 8'h08 + 8'(4 * p), v);
      xf(0, 8'h08 + 8'(4 * p), 0);
      `CHK(q, v)
      xf(0, 8'h38, 0);
      `CHK(q[1 + p], 1'b0)
      `CHK(p ? mul_b : mul_a, 12'(m + 1))
      `CHK(p ? pfr_b : pfr_a, 2'(r))
      repeat (200) @(posedge hclk);
      xf(0, 8'h38, 0);
      `CHK(q[1 + p], 1'b1)
      for (int d = 0; d < 4; d += 1 + d)
      begin
        xf(1, 8'h08 + 8'(4 * p), {v[31:8], 8'(d)});
        per(p);
        `CHK(n, d * 6)
      end
    end
    for (int u = 0; u < 4; u++)
    begin
      xf(1, 8'h0c, {2'h0, 2'(u), v[27:0]});
      per(7);
      `CHK(n, (u == 3) ? 0 : 12 << u)
    end
    for (int i = 0; i < 5; i++)
    begin
      s = (i == 0) ? 3 : $urandom_range(0, 3);
      pr = $urandom_range(0, 3);
      xf(1, 8'h10 + 8'(4 * i), {27'h0, 3'(pr), 2'(s)});
      per(2 + (i > 0) * i);
      `CHK(n, sp[s] << pr)
    end
    // PLL B off only after the select loop, whose first pass uses source PLL B
    xf(1, 8'h0c, 32'h0000_0201);
    repeat (200) @(posedge hclk);
    xf(0, 8'h38, 0);
    `CHK({en_b, q[2]}, 2'b00)
    xf(0, 8'h38, 0);
    `CHK(q, 32'h0000_0f0b)
    xf(1, 8'h30, 32'hffff_ffff);
    xf(0, 8'h3c, 0);
    `CHK(q, 32'h0000_0f0f)
    `CHK(irq, 1'b1)
    xf(1, 8'h34, 32'h0000_0f0b);
    xf(1, 8'h30, 32'h0);
    xf(0, 8'h3c, 0);
    `CHK(q, 32'h0000_0004)
    `CHK(irq, 1'b0)
    xf(1, 8'h10, 32'h0000_001d);
    per(2);
    `CHK(n, 0)
    xf(1, 8'h14, 32'h0000_001c);
    per(3);
    `CHK(n, 0)
    xf(0, 8'h80, 0);
    `CHK(q, 32'h0)
    results;
  end
endmodule

// [rtl/pmc_clock_ctrl.sv]
// Purpose: Clock generator configuration, measurement and status over AHB-Lite
// Assumes: Slow, main and PLL clocks arrive as pins, much slower than hclk
// Notes:   Derived clocks leave as one-cycle hclk ticks
`timescale 1ns/10ps
module pmc_clock_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        slow_clk_pin,
  input  wire logic        main_clk_pin,
  input  wire logic        pll_a_clk_pin,
  input  wire logic        pll_b_clk_pin,
  output logic             osc_enable,
  output logic             osc_bypass,
  output logic             pll_a_ref_tick,
  output logic             pll_b_ref_tick,
  output logic             pll_a_enable,
  output logic             pll_b_enable,
  output logic [11:0]      pll_a_mult,
  output logic [11:0]      pll_b_mult,
  output logic [1:0]       pll_a_freq_range,
  output logic [1:0]       pll_b_freq_range,
  output logic             mck_tick,
  output logic [3:0]       pck_tick,
  output logic             usb_tick,
  output logic             irq
);

  // Pin synchronisers: stage one, stage two, edge history
  logic [3:0]  sync1_r;            // First stage, read only by stage two
  logic [3:0]  sync2_r;            // Second stage
  logic [3:0]  sync3_r;            // Previous synced level
  logic [3:0]  edge_t;             // Rising edges: slow, main, A, B

  // Bus state
  logic        wr_pend_r;          // Write data phase pending
  logic        rd_pend_r;          // Read wait cycle pending
  logic [7:0]  addr_r;             // Latched address
  logic        accept;             // Address phase taken

  // Configuration registers
  logic [31:0]       osc_ctl_r;    // Oscillator enable, bypass, start count
  pmc_pkg::pmc_pll_cfg_t pll_r [2];   // PLL A and B settings
  pmc_pkg::pmc_clk_sel_t mck_r;       // Master clock select
  pmc_pkg::pmc_clk_sel_t pck_r [4];   // Programmable clock selects
  logic [11:0] mask_r;             // Interrupt enables

  // Oscillator and measurement state
  logic [10:0] osc_cnt_r;          // Start-up slow cycle count
  logic        osc_stable_r;       // Oscillator settled
  logic [3:0]  win_r;              // Slow periods in window
  logic        win_run_r;          // Window open
  logic [15:0] meas_cnt_r;         // Main cycles in window
  logic [15:0] main_freq_count_r;  // Last full count
  logic        main_count_valid_r; // Count is usable

  // Lock, ready state
  logic [5:0]  lock_cnt_r [2];     // Lock wait remaining
  logic [1:0]  lock_run_r;         // Lock wait in progress
  logic [1:0]  locked_r;           // Lock flags
  logic        mck_wait_r;         // Waiting for new master clock
  logic        mck_rdy_r;          // Master clock ready
  logic [3:0]  pck_wait_r;         // Waiting for programmable clocks
  logic [3:0]  pck_rdy_r;          // Programmable clocks ready

  // Derived ticks, status word and start target
  logic        slow_t;             // Slow clock edge
  logic        main_t;             // Main clock edge, oscillator settled
  logic [1:0]  pll_t;              // PLL outputs, gated by enable
  logic [3:0]  src_t;              // Sources: slow, main, A, B
  logic [1:0]  ref_t;              // Divider outputs to PLLs
  logic        mck_t;              // Master clock tick
  logic [3:0]  pck_t;              // Programmable clock ticks
  logic        usb_t;              // USB clock tick
  logic [11:0] status;             // Status word, low twelve bits
  logic [10:0] osc_target;         // Start count times eight

  // Write strobe for one register offset in its data phase
  function automatic logic wr_hit(input logic [7:0] off);
    return wr_pend_r && (addr_r == off);
  endfunction

  // Status assembly
  always_comb
  begin
    status                          = 12'h000;
    status[pmc_pkg::ST_OSC]         = osc_stable_r;
    status[pmc_pkg::ST_LOCK_A]      = locked_r[0];
    status[pmc_pkg::ST_LOCK_B]      = locked_r[1];
    status[pmc_pkg::ST_MCK_RDY]     = mck_rdy_r;
    status[pmc_pkg::ST_PCK0 +: 4]   = pck_rdy_r;
  end

  assign edge_t     = sync2_r & ~sync3_r;
  assign slow_t     = edge_t[0];
  assign main_t     = edge_t[1] & osc_stable_r;
  assign pll_t      = edge_t[3:2] & {pll_b_enable, pll_a_enable};
  assign src_t      = {pll_t[1], pll_t[0], main_t, slow_t};
  assign accept     = hsel && htrans[1] && hready;
  assign osc_target = {osc_ctl_r[pmc_pkg::OSC_CNT_LSB +: pmc_pkg::OSC_CNT_W],
                       3'h0};

  // Two-stage synchronisers for all clock pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {pll_b_clk_pin, pll_a_clk_pin, main_clk_pin, slow_clk_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Bus phases: writes take no wait, reads take one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= accept && hwrite;
      rd_pend_r <= accept && !hwrite;
      hreadyout <= !(accept && !hwrite);   // Stall so the read sees fresh state
      hresp     <= 1'b0;                   // Always OKAY
      if (accept)
      begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // Read data mux, unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= pmc_pkg::ZERO_WORD;
    end
    else if (rd_pend_r)
    begin
      hrdata <= pmc_pkg::ZERO_WORD;
      unique case (addr_r)
        pmc_pkg::OFF_OSC_CTRL:  hrdata <= osc_ctl_r;
        pmc_pkg::OFF_FREQ_MEAS: hrdata <= {15'h0000, main_count_valid_r,
                                           main_freq_count_r};
        pmc_pkg::OFF_PLL_A:     hrdata <= pll_r[0];
        pmc_pkg::OFF_PLL_B:     hrdata <= pll_r[1];
        pmc_pkg::OFF_MCK_SEL:   hrdata <= mck_r;
        pmc_pkg::OFF_STATUS:    hrdata <= {20'h00000, status};
        pmc_pkg::OFF_IRQ_MASK:  hrdata <= {20'h00000, mask_r};
        default:
        begin
          for (int i = 0; i < pmc_pkg::NUM_PCK; i++)
          begin
            if (addr_r == pmc_pkg::OFF_PCK0 + 8'(i) * pmc_pkg::PCK_STRIDE)
            begin
              hrdata <= pck_r[i];
            end
          end
        end
      endcase
    end
  end

  // Configuration register writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_ctl_r <= pmc_pkg::ZERO_WORD;
      pll_r[0]  <= pmc_pkg::PLL_RST;
      pll_r[1]  <= pmc_pkg::ZERO_WORD;
      mck_r     <= pmc_pkg::ZERO_WORD;
      for (int i = 0; i < pmc_pkg::NUM_PCK; i++)
      begin
        pck_r[i] <= pmc_pkg::ZERO_WORD;
      end
    end
    else
    begin
      if (wr_hit(pmc_pkg::OFF_OSC_CTRL))
      begin
        osc_ctl_r <= hwdata;
      end
      if (wr_hit(pmc_pkg::OFF_PLL_A))
      begin
        pll_r[0] <= hwdata;          // Bit 29 kept as software wrote it
      end
      if (wr_hit(pmc_pkg::OFF_PLL_B))
      begin
        pll_r[1] <= hwdata;
      end
      if (wr_hit(pmc_pkg::OFF_MCK_SEL))
      begin
        mck_r <= {27'h0000000, hwdata[4:0]};
      end
      for (int i = 0; i < pmc_pkg::NUM_PCK; i++)
      begin
        if (wr_hit(pmc_pkg::OFF_PCK0 + 8'(i) * pmc_pkg::PCK_STRIDE))
        begin
          pck_r[i] <= {27'h0000000, hwdata[4:0]};
        end
      end
    end
  end

  // Interrupt enable and disable by written ones
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_r <= 12'h000;
    end
    else
    begin
      if (wr_hit(pmc_pkg::OFF_IRQ_EN))
      begin
        mask_r <= mask_r | (hwdata[11:0] & pmc_pkg::IRQ_BITS);
      end
      else if (wr_hit(pmc_pkg::OFF_IRQ_DIS))
      begin
        mask_r <= mask_r & ~hwdata[11:0];
      end
    end
  end

  // Interrupt output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status & mask_r);
    end
  end

  // Oscillator start-up wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_cnt_r    <= 11'h000;
      osc_stable_r <= 1'b0;
    end
    else if (wr_hit(pmc_pkg::OFF_OSC_CTRL))
    begin
      osc_cnt_r    <= 11'h000;         // Restart on any change
      osc_stable_r <= 1'b0;
    end
    else if (osc_ctl_r[pmc_pkg::OSC_BYP_BIT])
    begin
      osc_stable_r <= 1'b1;            // Bypass: stable at once
    end
    else if (!osc_ctl_r[pmc_pkg::OSC_EN_BIT])
    begin
      osc_stable_r <= 1'b0;
      osc_cnt_r    <= 11'h000;
    end
    else if (osc_cnt_r >= osc_target)
    begin
      osc_stable_r <= 1'b1;
    end
    else if (slow_t)
    begin
      osc_cnt_r <= osc_cnt_r + 11'h001;
    end
  end

  // Main clock frequency measurement over sixteen slow periods
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_r              <= 4'h0;
      win_run_r          <= 1'b0;
      meas_cnt_r         <= 16'h0000;
      main_freq_count_r  <= 16'h0000;
      main_count_valid_r <= 1'b0;
    end
    else if (!osc_stable_r)
    begin
      win_run_r          <= 1'b0;      // Oscillator not settled: count invalid
      win_r              <= 4'h0;
      meas_cnt_r         <= 16'h0000;
      main_count_valid_r <= 1'b0;
    end
    else
    begin
      if (win_run_r && main_t)
      begin
        meas_cnt_r <= meas_cnt_r + 16'h0001;
      end
      if (slow_t)
      begin
        if (!win_run_r)
        begin
          win_run_r  <= 1'b1;          // Window opens on slow edge
          win_r      <= 4'h0;
          meas_cnt_r <= 16'h0000;
        end
        else if (win_r == pmc_pkg::MEAS_LAST)
        begin
          win_run_r          <= 1'b0;
          main_freq_count_r  <= meas_cnt_r + {15'h0000, main_t};
          main_count_valid_r <= 1'b1;
        end
        else
        begin
          win_r <= win_r + 4'h1;
        end
      end
    end
  end

  // PLL lock waits, restarted by each register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_run_r <= 2'b00;
      locked_r   <= 2'b00;
      for (int p = 0; p < 2; p++)
      begin
        lock_cnt_r[p] <= 6'h00;
      end
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (wr_hit(p == 0 ? pmc_pkg::OFF_PLL_A : pmc_pkg::OFF_PLL_B))
        begin
          locked_r[p]   <= 1'b0;
          lock_run_r[p] <= 1'b1;
          lock_cnt_r[p] <= hwdata[13:8];
        end
        else if (pll_r[p].mul == 11'h000)
        begin
          locked_r[p]   <= 1'b0;       // Deactivated PLL never locks
          lock_run_r[p] <= 1'b0;
        end
        else if (lock_run_r[p] && lock_cnt_r[p] == 6'h00)
        begin
          locked_r[p]   <= 1'b1;
          lock_run_r[p] <= 1'b0;
        end
        else if (lock_run_r[p] && slow_t)
        begin
          lock_cnt_r[p] <= lock_cnt_r[p] - 6'h01;
        end
      end
    end
  end

  // PLL and oscillator controls, registered output ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pll_a_enable     <= 1'b0;
      pll_b_enable     <= 1'b0;
      pll_a_mult       <= 12'h000;
      pll_b_mult       <= 12'h000;
      pll_a_freq_range <= 2'h0;
      pll_b_freq_range <= 2'h0;
      osc_enable       <= 1'b0;
      osc_bypass       <= 1'b0;
      pll_a_ref_tick   <= 1'b0;
      pll_b_ref_tick   <= 1'b0;
      mck_tick         <= 1'b0;
      pck_tick         <= 4'h0;
      usb_tick         <= 1'b0;
    end
    else
    begin
      pll_a_enable     <= pll_r[0].mul != 11'h000;
      pll_b_enable     <= pll_r[1].mul != 11'h000;
      pll_a_mult       <= {1'b0, pll_r[0].mul} + 12'h001;
      pll_b_mult       <= {1'b0, pll_r[1].mul} + 12'h001;
      pll_a_freq_range <= pll_r[0].range;
      pll_b_freq_range <= pll_r[1].range;
      osc_enable       <= osc_ctl_r[pmc_pkg::OSC_EN_BIT];
      osc_bypass       <= osc_ctl_r[pmc_pkg::OSC_BYP_BIT];
      pll_a_ref_tick   <= ref_t[0];
      pll_b_ref_tick   <= ref_t[1];
      mck_tick         <= mck_t;
      pck_tick         <= pck_t;
      usb_tick         <= usb_t;
    end
  end

  // Ready flags follow the first tick after a reprogram
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mck_wait_r <= 1'b1;
      mck_rdy_r  <= 1'b0;
      pck_wait_r <= 4'hf;
      pck_rdy_r  <= 4'h0;
    end
    else
    begin
      if (wr_hit(pmc_pkg::OFF_MCK_SEL))
      begin
        mck_wait_r <= 1'b1;
        mck_rdy_r  <= 1'b0;
      end
      else if (mck_wait_r && mck_t)
      begin
        mck_wait_r <= 1'b0;
        mck_rdy_r  <= 1'b1;
      end
      for (int i = 0; i < pmc_pkg::NUM_PCK; i++)
      begin
        if (wr_hit(pmc_pkg::OFF_PCK0 + 8'(i) * pmc_pkg::PCK_STRIDE))
        begin
          pck_wait_r[i] <= 1'b1;
          pck_rdy_r[i]  <= 1'b0;
        end
        else if (pck_wait_r[i] && pck_t[i])
        begin
          pck_wait_r[i] <= 1'b0;
          pck_rdy_r[i]  <= 1'b1;
        end
      end
    end
  end

  // PLL input dividers, both fed from the main clock
  pmc_tick_div u_div_a (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (main_t),
    .ratio    (pll_r[0].in_div),
    .tick_out (ref_t[0])
  );

  pmc_tick_div u_div_b (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (main_t),
    .ratio    (pll_r[1].in_div),
    .tick_out (ref_t[1])
  );

  // USB divider on PLL B output
  pmc_tick_div u_div_usb (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (pll_t[1]),
    .ratio    (pmc_pkg::usb_ratio(pll_r[1].usb_div)),
    .tick_out (usb_t)
  );

  // Master clock: source select then prescaler
  pmc_tick_div u_div_mck (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (src_t[mck_r.src]),
    .ratio    (pmc_pkg::clock_prescaler_ratio(mck_r.clock_prescaler)),
    .tick_out (mck_t)
  );

  // Programmable clocks: source select then prescaler each
  for (genvar g = 0; g < pmc_pkg::NUM_PCK; g++)
  begin : g_pck
    pmc_tick_div u_div_pck (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick_in  (src_t[pck_r[g].src]),
      .ratio    (pmc_pkg::clock_prescaler_ratio(pck_r[g].clock_prescaler)),
      .tick_out (pck_t[g])
    );
  end

endmodule

// [rtl/pmc_pkg.sv]
// Purpose: Shared constants, layouts and helpers of the clock configuration block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses inside the block window
//
// Notes on behaviour
// - Count main clocks over 16 slow periods
// - Valid flag low until oscillator on, count done
// - PLL A divider: 0 none, 1 bypass, else divide
// - PLL A lock flag after programmed slow cycles
// - PLL A multiplier zero off, else times field+1
// - PLL B divider: 0 none, 1 bypass, else divide
// - PLL B lock flag after programmed slow cycles
// - PLL B multiplier zero off, else times field+1
// - USB divider passes, halves, quarters; 11 reserved
// - Master source: slow, main, PLL A, PLL B clock
// - Master prescaler divides by powers 1 to 64
// - Programmable clock source: slow, main, A, B
// - Programmable prescaler divides by powers 1 to 64
// - Enable register sets interrupt enables by ones
// - Disable register clears interrupt enables by ones
// - Status layout: flags at 0-3 and 8-11
// - Oscillator stable after start count times eight
package pmc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_OSC_CTRL  = 8'h00;
  localparam logic [7:0] OFF_FREQ_MEAS = 8'h04;
  localparam logic [7:0] OFF_PLL_A     = 8'h08;
  localparam logic [7:0] OFF_PLL_B     = 8'h0c;
  localparam logic [7:0] OFF_MCK_SEL   = 8'h10;
  localparam logic [7:0] OFF_PCK0      = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h30;
  localparam logic [7:0] OFF_IRQ_DIS   = 8'h34;
  localparam logic [7:0] OFF_STATUS    = 8'h38;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h3c;

  // Word stride between programmable clock registers
  localparam logic [7:0] PCK_STRIDE    = 8'h04;
  localparam int         NUM_PCK       = 4;

  // Status and interrupt bit positions
  localparam int         ST_OSC        = 0;
  localparam int         ST_LOCK_A     = 1;
  localparam int         ST_LOCK_B     = 2;
  localparam int         ST_MCK_RDY    = 3;
  localparam int         ST_PCK0       = 8;
  localparam logic [11:0] IRQ_BITS     = 12'hf0f;

  // Frequency measurement layout and window
  localparam int         FREQ_W        = 16;
  localparam int         FREQ_VALID_BIT = 16;
  localparam logic [3:0] MEAS_LAST     = 4'hf;

  // Oscillator control layout
  localparam int         OSC_EN_BIT    = 0;
  localparam int         OSC_BYP_BIT   = 1;
  localparam int         OSC_CNT_LSB   = 8;
  localparam int         OSC_CNT_W     = 8;
  localparam int         OSC_MUL_SH    = 3;

  // Master and programmable clock layout
  localparam int         CSS_LSB       = 0;
  localparam int         CLOCK_PRESCALER_LSB      = 2;

  // Reset values
  localparam logic [31:0] PLL_RST      = 32'h2000_0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  // PLL configuration word, laid out as the register
  typedef struct packed {
    logic [1:0]  pad_hi;      // Bits 31:30
    logic [1:0]  usb_div;     // Bits 29:28, USB divider on B
    logic        pad_mid;     // Bit 27
    logic [10:0] mul;         // Bits 26:16
    logic [1:0]  range;       // Bits 15:14
    logic [5:0]  lock_wait;   // Bits 13:8
    logic [7:0]  in_div;      // Bits 7:0
  } pmc_pll_cfg_t;

  // Clock select word: source and prescaler
  typedef struct packed {
    logic [26:0] pad;         // Reads as zero
    logic [2:0]  clock_prescaler;
    logic [1:0]  src;
  } pmc_clk_sel_t;

  // Prescaler code to division ratio, reserved gives no output
  function automatic logic [7:0] clock_prescaler_ratio(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    if (code != 3'h7)
    begin
      r = 8'h01 << code;
    end
    return r;
  endfunction

  // USB divider code to ratio, reserved gives no output
  function automatic logic [7:0] usb_ratio(input logic [1:0] code);
    logic [7:0] r;
    r = 8'h00;
    if (code != 2'h3)
    begin
      r = 8'h01 << code;
    end
    return r;
  endfunction

endpackage

// [rtl/pmc_tick_div.sv]
// Purpose: Divides a stream of one-cycle ticks by a programmable ratio
// Assumes: tick_in is a single-cycle strobe on hclk
// Notes:   Ratio zero stops the output; ratio one passes every tick
`timescale 1ns/10ps
module pmc_tick_div (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick_in,
  input  wire logic [7:0] ratio,
  output logic            tick_out
);

  logic [7:0] cnt_r;       // Ticks seen in current period

  // Count input ticks, emit one per full period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r    <= 8'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (ratio == 8'h00)
      begin
        cnt_r <= 8'h00;      // Output held at zero
      end
      else if (tick_in)
      begin
        if (cnt_r >= ratio - 8'h01)
        begin
          cnt_r    <= 8'h00;
          tick_out <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

endmodule
